//--- design/isq_sequencer.sv
// How it works
// [RULE1] section 00 of each instruction holds channel, resolution and sequencing fields
// [RULE2] loop bit marks the last instruction; next one is instruction zero
// [RULE3] pause bit halts after fetch, before execute, and clears start
// [RULE4] a pause halt raises the halt interrupt, number five
// [RULE5] writing start one resumes the halted instruction
// [RULE6] soft reset fetches and decodes instruction zero, then waits for start
// [RULE7] first run of instruction zero after start ignores its pause bit
// [RULE8] started sequencer executes instructions in ascending order
// [RULE9] after loop or all eight, instruction zero halts before executing
// [RULE10] bits 2 to 4 pick the non-inverting input, inputs zero to seven
// [RULE11] bits 5 to 7 pick the inverting input; code zero means ground
// [RULE12] sync bit waits after acquisition for a trigger rise, then converts
// [RULE13] host clears trigger direction bit before using the trigger as input
// [RULE14] window compare with sync needs two trigger rises, limit one then two
// [RULE15] timer bit waits for the countdown to reach zero, no conversion meanwhile
// [RULE16] bit 10 selects eight bits plus sign, else twelve bits plus sign
// [RULE17] bit 11 runs two limit comparisons instead of one conversion
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module isq_sequencer #(
	parameter int ACQ_CYCLES = isq_pkg::ACQ_CYCLES_DEF
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter control
	output logic [2:0] noninverting_channel_select,
	output logic [2:0] inverting_channel_select,
	output logic single_ended,
	output logic res_8bit,
	output logic window_compare,
	output logic limit_sel,
	output logic conv_start,
	input wire logic conv_done,
	// trigger pin
	input wire logic trigger_i,
	output logic trigger_o,
	output logic trigger_oe,
	// halt event
	output logic pause_int
);
	localparam logic [15:0] ACQ_LOAD = 16'(ACQ_CYCLES - 1);

	isq_mem_if mif ();
	isq_pkg::isq_state_e state_r;
	logic [isq_pkg::PC_W-1:0] pc_r;
	logic [isq_pkg::INSTR_W-1:0] instr_r, exec_w;
	logic [15:0] cnt_r;
	logic first_r, phase_r, start_r, iosel_r, halted_r, pause_int_r;
	logic [isq_pkg::TIMER_W-1:0] preset_r;
	logic aw_held_r, w_held_r, bvalid_r, rd_busy_r, rd_ph_r, rvalid_r;
	logic [5:0] awaddr_r, araddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [2:0] trig_sync_r;
	logic trig_rise, wr_fire, soft_rst, cfg_wr, halt_cond, halt_any, halt_evt;
	logic [3:0] widx, ridx;

	isq_instr_mem u_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.mp(mif.mem)
	);

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign widx = awaddr_r[5:2];
	assign cfg_wr = wr_fire && widx == isq_pkg::IDX_CONFIG && wstrb_r[0];
	assign soft_rst = cfg_wr && wdata_r[isq_pkg::CFG_RESET];
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= isq_pkg::RESP_OKAY;
			awaddr_r <= 6'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (widx <= isq_pkg::IDX_TIMER) ? isq_pkg::RESP_OKAY : isq_pkg::RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// instruction store ports; partial writes of a word are dropped
	assign mif.we = wr_fire && !widx[3] && wstrb_r[1:0] == 2'h3;
	assign mif.waddr = widx[2:0];
	assign mif.wdata = wdata_r[15:0];
	assign mif.seq_raddr = pc_r;
	assign mif.bus_raddr = araddr_r[4:2];

	// read channel: two cycles from address to data, to let the store answer
	assign ridx = araddr_r[5:2];
	assign s_axi_arready = !rd_busy_r && !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_busy_r <= 1'b0;
			rd_ph_r <= 1'b0;
			rvalid_r <= 1'b0;
			araddr_r <= 6'h00;
			rdata_r <= 32'h0000_0000;
			rresp_r <= isq_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_busy_r <= 1'b1;
			rd_ph_r <= 1'b0;
			araddr_r <= s_axi_araddr;
		end else if (rd_busy_r && !rd_ph_r) begin
			rd_ph_r <= 1'b1;
		end else if (rd_busy_r) begin
			rd_busy_r <= 1'b0;
			rd_ph_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= isq_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			if (!ridx[3]) begin
				rdata_r <= {16'h0000, mif.bus_rdata};
			end else if (ridx == isq_pkg::IDX_CONFIG) begin
				rdata_r[isq_pkg::CFG_START] <= start_r;
				rdata_r[isq_pkg::CFG_IOSEL] <= iosel_r;
			end else if (ridx == isq_pkg::IDX_STATUS) begin
				rdata_r[isq_pkg::STS_HALTED] <= halted_r;
				rdata_r[isq_pkg::STS_WAITING] <= state_r == isq_pkg::S_WAIT;
				rdata_r[isq_pkg::STS_TIMING] <= state_r == isq_pkg::S_TIMER;
				rdata_r[isq_pkg::STS_PC_LO +: isq_pkg::PC_W] <= pc_r;
			end else if (ridx == isq_pkg::IDX_TIMER) begin
				rdata_r <= {16'h0000, preset_r};
			end else begin
				rresp_r <= isq_pkg::RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// halt decisions at decode: wrap back to zero halts, as does a pause bit
	assign halt_cond = !first_r && (pc_r == isq_pkg::PC_FIRST || mif.seq_rdata[isq_pkg::INS_PAUSE]);
	assign halt_any = state_r == isq_pkg::S_DECODE && start_r && halt_cond;
	assign halt_evt = halt_any && mif.seq_rdata[isq_pkg::INS_PAUSE];
	assign exec_w = (state_r == isq_pkg::S_DECODE) ? mif.seq_rdata : instr_r;

	// start, direction and timer preset; a software write wins over the auto clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_r <= 1'b0;
			iosel_r <= 1'b0;
			preset_r <= isq_pkg::TIMER_RST;
		end else begin
			if (cfg_wr) begin
				start_r <= wdata_r[isq_pkg::CFG_START];
				iosel_r <= wdata_r[isq_pkg::CFG_IOSEL];
			// [RULE3] start auto clear
			end else if (halt_any) begin
				start_r <= 1'b0;
			end
			if (wr_fire && widx == isq_pkg::IDX_TIMER) begin
				if (wstrb_r[0]) preset_r[7:0] <= wdata_r[7:0];
				if (wstrb_r[1]) preset_r[15:8] <= wdata_r[15:8];
			end
		end
	end

	// sticky halt flag, write one to clear; a new halt wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halted_r <= 1'b0;
			pause_int_r <= 1'b0;
		end else begin
			// [RULE4] halt interrupt five
			pause_int_r <= halt_evt;
			if (halt_evt) begin
				halted_r <= 1'b1;
			end else if (wr_fire && widx == isq_pkg::IDX_STATUS && wstrb_r[0]
				&& wdata_r[isq_pkg::STS_HALTED]) begin
				halted_r <= 1'b0;
			end
		end
	end
	assign pause_int = pause_int_r;

	// trigger pin: two flops, then edge detect on the later pair
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_sync_r <= 3'h0;
		end else begin
			trig_sync_r <= {trig_sync_r[1:0], trigger_i};
		end
	end
	assign trig_rise = trig_sync_r[1] && !trig_sync_r[2];
	// [RULE13] direction follows the host bit; pin echoes conversion starts when driven
	assign trigger_oe = iosel_r;
	assign trigger_o = conv_start;

	// sequencer; [RULE1] every word is decoded with the section 00 layout, no section bits checked
	always_ff @(posedge aclk) begin
		// [RULE6] soft reset refetches zero
		if (!aresetn || soft_rst) begin
			state_r <= isq_pkg::S_FETCH;
			pc_r <= isq_pkg::PC_FIRST;
			first_r <= 1'b1;
			phase_r <= 1'b0;
			cnt_r <= 16'h0000;
			instr_r <= isq_pkg::INSTR_RST;
		end else begin
			case (state_r)
				isq_pkg::S_FETCH: begin
					state_r <= isq_pkg::S_DECODE;
				end
				isq_pkg::S_DECODE, isq_pkg::S_WAIT: begin
					if (state_r == isq_pkg::S_DECODE) begin
						instr_r <= mif.seq_rdata;
					end
					// [RULE9] wrap halt at zero
					if (!start_r || (state_r == isq_pkg::S_DECODE && halt_cond)) begin
						state_r <= isq_pkg::S_WAIT;
					// [RULE5] resume halted instruction
					end else begin
						// [RULE7] first pass skips the pause
						first_r <= 1'b0;
						phase_r <= 1'b0;
						// [RULE15] timer wait first
						if (exec_w[isq_pkg::INS_TIMER]) begin
							state_r <= isq_pkg::S_TIMER;
							cnt_r <= preset_r;
						end else begin
							state_r <= isq_pkg::S_ACQ;
							cnt_r <= ACQ_LOAD;
						end
					end
				end
				isq_pkg::S_TIMER: begin
					if (cnt_r == 16'h0000) begin
						state_r <= isq_pkg::S_ACQ;
						cnt_r <= ACQ_LOAD;
					end else begin
						cnt_r <= cnt_r - 16'h0001;
					end
				end
				isq_pkg::S_ACQ: begin
					// [RULE12] hold at end of acquisition
					if (cnt_r == 16'h0000) begin
						state_r <= instr_r[isq_pkg::INS_SYNC] ? isq_pkg::S_SYNC : isq_pkg::S_CONV;
					end else begin
						cnt_r <= cnt_r - 16'h0001;
					end
				end
				isq_pkg::S_SYNC: begin
					if (trig_rise) begin
						state_r <= isq_pkg::S_CONV;
					end
				end
				isq_pkg::S_CONV: begin
					state_r <= isq_pkg::S_CWAIT;
				end
				isq_pkg::S_CWAIT: begin
					if (conv_done) begin
						// [RULE17] second comparison
						// [RULE14] second trigger edge
						if (instr_r[isq_pkg::INS_WDOG] && !phase_r) begin
							phase_r <= 1'b1;
							state_r <= instr_r[isq_pkg::INS_SYNC] ? isq_pkg::S_SYNC : isq_pkg::S_CONV;
						end else begin
							state_r <= isq_pkg::S_NEXT;
						end
					end
				end
				isq_pkg::S_NEXT: begin
					state_r <= isq_pkg::S_FETCH;
					// [RULE2] loop returns to zero
					if (instr_r[isq_pkg::INS_LOOP] || pc_r == isq_pkg::PC_LAST) begin
						pc_r <= isq_pkg::PC_FIRST;
					// [RULE8] ascending order
					end else begin
						pc_r <= pc_r + 3'h1;
					end
				end
				default: begin
					state_r <= isq_pkg::S_FETCH;
				end
			endcase
		end
	end

	// converter channel, resolution and window controls straight from the held instruction; limit select and start from the state
	// [RULE10] non-inverting input
	assign noninverting_channel_select = instr_r[isq_pkg::INS_NINV_LO +: 3];
	// [RULE11] inverting input, zero is ground
	assign inverting_channel_select = instr_r[isq_pkg::INS_INV_LO +: 3];
	assign single_ended = instr_r[isq_pkg::INS_INV_LO +: 3] == 3'h0;
	// [RULE16] resolution select
	assign res_8bit = instr_r[isq_pkg::INS_RES8];
	assign window_compare = instr_r[isq_pkg::INS_WDOG];
	assign limit_sel = phase_r;
	assign conv_start = state_r == isq_pkg::S_CONV;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence seq_decode_go;
		state_r == isq_pkg::S_DECODE && start_r && !halt_cond && !soft_rst;
	endsequence
	sequence seq_pause_halt;
		halt_evt && !cfg_wr && !soft_rst;
	endsequence

	AST_LOOP_WRAP: assert property (state_r == isq_pkg::S_NEXT && instr_r[isq_pkg::INS_LOOP]
		&& !soft_rst |=> pc_r == isq_pkg::PC_FIRST) // [RULE2]
		else $error("loop bit did not return to instruction zero");
	AST_PAUSE_STOP: assert property (seq_pause_halt |=> !start_r
		&& state_r == isq_pkg::S_WAIT) // [RULE3]
		else $error("pause did not stop and clear start");
	AST_PAUSE_INT: assert property (seq_pause_halt |=> pause_int ##1 !pause_int) // [RULE4]
		else $error("pause halt did not pulse the interrupt");
	AST_RESUME: assert property (state_r == isq_pkg::S_WAIT && start_r && !soft_rst
		|=> state_r != isq_pkg::S_WAIT && $stable(pc_r)) // [RULE5]
		else $error("start did not resume the halted instruction");
	AST_SOFT_RESET: assert property (soft_rst |=> state_r == isq_pkg::S_FETCH
		&& pc_r == isq_pkg::PC_FIRST ##1 state_r == isq_pkg::S_DECODE) // [RULE6]
		else $error("soft reset did not refetch instruction zero");
	AST_FIRST_NO_INT: assert property ((state_r == isq_pkg::S_DECODE || state_r == isq_pkg::S_WAIT)
		&& first_r && start_r && !soft_rst |=> !pause_int && state_r != isq_pkg::S_WAIT) // [RULE7]
		else $error("pause honoured on first pass of instruction zero");
	AST_ASCEND: assert property (state_r == isq_pkg::S_NEXT && !instr_r[isq_pkg::INS_LOOP]
		&& pc_r != isq_pkg::PC_LAST && !soft_rst |=> pc_r == $past(pc_r) + 3'h1) // [RULE8]
		else $error("instruction address did not step by one");
	AST_WRAP_HALT: assert property (state_r == isq_pkg::S_DECODE && !first_r
		&& pc_r == isq_pkg::PC_FIRST && !soft_rst |=> state_r == isq_pkg::S_WAIT) // [RULE9]
		else $error("instruction zero did not halt after wrap");
	AST_SYNC_EDGE: assert property (state_r == isq_pkg::S_SYNC && trig_rise && !soft_rst
		|=> conv_start) // [RULE12]
		else $error("trigger edge did not start conversion next cycle");
	AST_TIMER_QUIET: assert property (seq_decode_go ##0 exec_w[isq_pkg::INS_TIMER]
		|=> (!conv_start throughout state_r == isq_pkg::S_TIMER [*1])) // [RULE15]
		else $error("conversion during timer wait");
	AST_WDOG_TWO: assert property (state_r == isq_pkg::S_CWAIT && conv_done && window_compare
		&& !limit_sel && !soft_rst |=> limit_sel && state_r != isq_pkg::S_NEXT) // [RULE17]
		else $error("window compare skipped second limit");
endmodule
`default_nettype wire

//--- design/isq_pkg.sv
package isq_pkg;
	// register byte offsets on the control bus
	localparam logic [5:0] ADDR_INSTR0 = 6'h00;
	localparam logic [5:0] ADDR_CONFIG = 6'h20;
	localparam logic [5:0] ADDR_STATUS = 6'h24;
	localparam logic [5:0] ADDR_TIMER = 6'h28;
	localparam logic [3:0] IDX_CONFIG = 4'h8;
	localparam logic [3:0] IDX_STATUS = 4'h9;
	localparam logic [3:0] IDX_TIMER = 4'hA;

	// configuration bits
	localparam int CFG_START = 0;
	localparam int CFG_RESET = 1;
	localparam int CFG_IOSEL = 7;

	// status bits
	localparam int STS_HALTED = 0;
	localparam int STS_WAITING = 1;
	localparam int STS_TIMING = 2;
	localparam int STS_PC_LO = 4;

	// instruction word, section 00
	localparam int INS_LOOP = 0;
	localparam int INS_PAUSE = 1;
	localparam int INS_NINV_LO = 2;
	localparam int INS_INV_LO = 5;
	localparam int INS_SYNC = 8;
	localparam int INS_TIMER = 9;
	localparam int INS_RES8 = 10;
	localparam int INS_WDOG = 11;

	// sizes and reset values
	localparam int INSTR_W = 16;
	localparam int INSTR_DEPTH = 8;
	localparam int PC_W = 3;
	localparam int TIMER_W = 16;
	localparam logic [PC_W-1:0] PC_FIRST = 3'h0;
	localparam logic [PC_W-1:0] PC_LAST = 3'h7;
	localparam logic [TIMER_W-1:0] TIMER_RST = 16'h0000;
	localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;
	localparam int ACQ_CYCLES_DEF = 4;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		S_FETCH, S_DECODE, S_WAIT, S_TIMER, S_ACQ, S_SYNC, S_CONV, S_CWAIT, S_NEXT
	} isq_state_e;
endpackage

//--- design/isq_mem_if.sv
`timescale 1ns/1ns
`default_nettype none
// write port and two read ports of the instruction store
interface isq_mem_if;
	logic we;
	logic [isq_pkg::PC_W-1:0] waddr;
	logic [isq_pkg::INSTR_W-1:0] wdata;
	logic [isq_pkg::PC_W-1:0] seq_raddr;
	logic [isq_pkg::INSTR_W-1:0] seq_rdata;
	logic [isq_pkg::PC_W-1:0] bus_raddr;
	logic [isq_pkg::INSTR_W-1:0] bus_rdata;
	modport owner (output we, waddr, wdata, seq_raddr, bus_raddr, input seq_rdata, bus_rdata);
	modport mem (input we, waddr, wdata, seq_raddr, bus_raddr, output seq_rdata, bus_rdata);
endinterface
`default_nettype wire

//--- design/isq_instr_mem.sv
`timescale 1ns/1ns
`default_nettype none
module isq_instr_mem (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// store port
	isq_mem_if.mem mp
);
	logic [isq_pkg::INSTR_W-1:0] mem_r [isq_pkg::INSTR_DEPTH];

	// array holds no reset, software programs it before use
	always_ff @(posedge aclk) begin
		if (mp.we) begin
			mem_r[mp.waddr] <= mp.wdata;
		end
	end

	// both read ports registered, one cycle of latency
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mp.seq_rdata <= isq_pkg::INSTR_RST;
			mp.bus_rdata <= isq_pkg::INSTR_RST;
		end else begin
			mp.seq_rdata <= mem_r[mp.seq_raddr];
			mp.bus_rdata <= mem_r[mp.bus_raddr];
		end
	end
endmodule
`default_nettype wire

//--- dv/isq_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side: converter answering each start, plus an external trigger source
module isq_conv_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// converter link
	input wire logic conv_start,
	output logic conv_done,
	input wire logic [3:0] dly,
	// trigger source
	input wire logic trig_fire,
	output logic trig_src
);
	logic busy_r;
	logic [3:0] cnt_r;
	logic [2:0] tcnt_r;

	// one answer per start
	// each start gets exactly one done dly+2 cycles after the start cycle, so pairing slips show up
	always_ff @(posedge aclk) begin
		conv_done <= 1'b0;
		if (!aresetn) begin
			busy_r <= 1'b0;
			cnt_r <= 4'h0;
		end else if (conv_start) begin
			busy_r <= 1'b1;
			cnt_r <= dly;
		end else if (busy_r) begin
			if (cnt_r == 4'h0) begin
				conv_done <= 1'b1;
				busy_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end

	// trigger rises
	// pin held high a few cycles so the two-flop synchroniser cannot miss it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tcnt_r <= 3'h0;
		end else if (trig_fire) begin
			tcnt_r <= 3'h4;
		end else if (tcnt_r != 3'h0) begin
			tcnt_r <= tcnt_r - 3'h1;
		end
	end
	assign trig_src = (tcnt_r != 3'h0);
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic aclk, aresetn;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
	logic [3:0] s_axi_wstrb, dly;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [2:0] ninv, inv;
	logic se, r8, win, lsel, conv_start, conv_done, trig_o, trig_oe, pause_int;
	logic trig_fire, trig_src, trig_w;
	int fail_count, total_checks, pcnt, cyc, p1;
	logic [9:0] got_q[$], exp_q[$];
	int stamp_q[$];
	localparam int TMR = 40;

	isq_sequencer #(.ACQ_CYCLES(2)) i_isq_sequencer (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.noninverting_channel_select(ninv), .inverting_channel_select(inv), .single_ended(se),
		.res_8bit(r8), .window_compare(win), .limit_sel(lsel), .conv_start(conv_start),
		.conv_done(conv_done), .trigger_i(trig_w), .trigger_o(trig_o), .trigger_oe(trig_oe),
		.pause_int(pause_int));
	isq_conv_model i_isq_conv_model (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
		.conv_done(conv_done), .dly(dly), .trig_fire(trig_fire), .trig_src(trig_src));

	// trigger wire: device drives only while its enable is up
	assign trig_w = trig_oe ? trig_o : trig_src;

	// 125 MHz clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// log every conversion start with the select outputs standing at that edge
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (pause_int === 1'b1) pcnt <= pcnt + 1;
		if (conv_start === 1'b1) begin
			got_q.push_back({lsel, win, r8, se, inv, ninv});
			stamp_q.push_back(cyc);
		end
	end

	function automatic logic [9:0] tup(input logic ls, w, r, input logic [2:0] iv, nv);
		return {ls, w, r, (iv == 3'h0), iv, nv};
	endfunction

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic give_up(input int n);
		if (n >= 300) begin
			fail_count++;
			end_of_test();
		end
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ad, wd;
		ad = 0;
		wd = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 300 && !(ad && wd); n++) begin
			@(posedge aclk);
			if (!ad && s_axi_awready === 1'b1) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready === 1'b1) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		give_up(n);
		s_axi_bready <= 1'b1;
		for (n = 0; n < 300; n++) begin
			@(posedge aclk);
			if (s_axi_bvalid === 1'b1) break;
		end
		give_up(n);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 300; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) break;
		end
		give_up(n);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 300; n++) begin
			@(posedge aclk);
			if (s_axi_rvalid === 1'b1) break;
		end
		give_up(n);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wait_conv(input int k);
		int n;
		for (n = 0; n < 300 && got_q.size() < k; n++) @(posedge aclk);
		give_up(n);
	endtask

	// poll until the start bit has been cleared by a halt
	task automatic wait_halt();
		int n;
		rd_v = 32'h0000_0001;
		for (n = 0; n < 300 && rd_v[0] !== 1'b0; n++) rd(isq_pkg::ADDR_CONFIG, rd_v, rsp);
		give_up(n);
		repeat (3) @(posedge aclk);
	endtask

	task automatic fire();
		trig_fire <= 1'b1;
		@(posedge aclk);
		trig_fire <= 1'b0;
	endtask

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		{trig_fire, dly} = '0;
		{fail_count, total_checks, pcnt, cyc} = '0;
		aresetn = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(isq_pkg::ADDR_CONFIG, rd_v, rsp);
		chk(rd_v, 32'h0000_0000);
		rd(isq_pkg::ADDR_STATUS, rd_v, rsp);
		chk(rd_v & 32'h0000_0073, 32'h0000_0002);
		// unmapped word: error answer on both channels, read data zero
		rd(6'h2C, rd_v, rsp);
		chk(rd_v, 32'h0000_0000);
		chk({30'h0, rsp}, {30'h0, isq_pkg::RESP_SLVERR});
		wr(6'h2C, 32'h0000_0000, rsp);
		chk({30'h0, rsp}, {30'h0, isq_pkg::RESP_SLVERR});
		$display("test reset_and_map done");
		// pause on 0, window with sync on 1, timer plus loop on 2
		wr(6'h00, 32'h0000_040E, rsp);
		wr(6'h04, 32'h0000_0954, rsp);
		wr(6'h08, 32'h0000_02FD, rsp);
		wr(isq_pkg::ADDR_TIMER, TMR, rsp);
		chk({30'h0, rsp}, {30'h0, isq_pkg::RESP_OKAY});
		rd(isq_pkg::ADDR_TIMER, rd_v, rsp);
		chk(rd_v, TMR);
		exp_q = '{tup(0, 0, 1, 3'h0, 3'h3), tup(0, 1, 0, 3'h2, 3'h5), tup(1, 1, 0, 3'h2, 3'h5),
			tup(0, 0, 0, 3'h7, 3'h7), tup(0, 0, 1, 3'h0, 3'h3)};
		// held word was decoded before programming, so refetch instruction zero
		wr(isq_pkg::ADDR_CONFIG, 32'h0000_0002, rsp);
		wr(isq_pkg::ADDR_CONFIG, 32'h0000_0001, rsp);
		wait_conv(1);
		repeat (4) @(posedge aclk);
		p1 = pcnt;
		chk(p1, 0);
		repeat (40) @(posedge aclk);
		chk(got_q.size(), 1);
		fire();
		wait_conv(2);
		repeat (40) @(posedge aclk);
		chk(got_q.size(), 2);
		fire();
		wait_conv(4);
		chk(stamp_q[3] - stamp_q[2] > TMR, 1);
		wait_halt();
		chk(pcnt, 1);
		rd(isq_pkg::ADDR_STATUS, rd_v, rsp);
		chk(rd_v & 32'h0000_0071, 32'h0000_0001);
		chk(got_q.size(), 4);
		$display("test first_pass done");
		wr(isq_pkg::ADDR_CONFIG, 32'h0000_0001, rsp);
		wait_conv(5);
		chk(pcnt, 1);
		wr(isq_pkg::ADDR_CONFIG, 32'h0000_0002, rsp);
		rd(isq_pkg::ADDR_STATUS, rd_v, rsp);
		chk(rd_v & 32'h0000_0072, 32'h0000_0002);
		rd(isq_pkg::ADDR_CONFIG, rd_v, rsp);
		chk(rd_v, 32'h0000_0000);
		// pin driven only while the direction bit is set
		wr(isq_pkg::ADDR_CONFIG, 32'h0000_0080, rsp);
		rd(isq_pkg::ADDR_CONFIG, rd_v, rsp);
		chk(rd_v, 32'h0000_0080);
		chk({30'h0, trig_oe, trig_o}, 32'h0000_0002);
		$display("test resume_and_soft_reset done");
		// all eight slots, every channel code, slower converter answer
		dly <= 4'h5;
		for (int i = 0; i < 8; i++) begin
			wr(6'(4 * i), (i << 2) | ((7 - i) << 5) | ((i & 1) << 10), rsp);
			exp_q.push_back(tup(0, 0, 1'(i), 3'(7 - i), 3'(i)));
		end
		wr(isq_pkg::ADDR_TIMER, 32'h0000_0000, rsp);
		// soft reset after programming, also returns the pin to input
		wr(isq_pkg::ADDR_CONFIG, 32'h0000_0002, rsp);
		wr(isq_pkg::ADDR_CONFIG, 32'h0000_0001, rsp);
		wait_conv(13);
		wait_halt();
		chk(pcnt, 1);
		rd(isq_pkg::ADDR_STATUS, rd_v, rsp);
		chk(rd_v & 32'h0000_0070, 32'h0000_0000);
		chk(got_q.size(), exp_q.size());
		for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
			chk(got_q[i], exp_q[i]);
		end
		$display("test eight_slots done");
		end_of_test();
	end
endmodule
`default_nettype wire
